/* verilog/sbcseq_device.sv */
`timescale 1ns/1ps
`default_nettype none
module sbcseq_device import sbcseq_pkg::*; #(
  parameter int UV_CYCLES   = UV_CYC,
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int LONG_CYCLES = LONG_CYC,
  parameter int MID_CYCLES  = MID_CYC,
  parameter int SHRT_CYCLES = SHRT_CYC,
  parameter int DEEP_CYCLES = DEEP_CYC
) (
  input  wire logic     I_CLOCK,
  input  wire logic     I_NRST,
  sbcseq_link_if.dev    LINK,
  input  wire logic     I_LOWSIDE_GATE_PIN_HIGH,
  input  wire logic     I_PRE_SS_DONE,
  input  wire logic     I_SELECT_TO_PRE,
  input  wire logic     I_RAILS_SS_DONE,
  input  wire logic     I_PRE_UV,
  input  wire logic     I_BAT_UV,
  input  wire logic     I_WAKE_CAN,
  input  wire logic     I_WAKE_LIN,
  input  wire logic     I_WAKE_IO,
  input  wire logic     I_KEY,
  input  wire logic     I_LOGIC_SELF_TEST_DONE,
  input  wire logic     I_LOGIC_SELF_TEST_OK,
  input  wire logic     I_ANALOG_SELF_TEST_DONE,
  input  wire logic     I_ANALOG_SELF_TEST_OK,
  input  wire logic     I_FAULT,
  input  wire logic     I_WD_GOOD,
  input  wire logic     I_WD_ERR,
  output logic          O_LOWSIDE_GATE_PIN_SRC,
  output logic          O_TOPO_BUCKBOOST,
  output logic          O_PRE_EN,
  output logic          O_PRE_BOOST,
  output logic          O_PRE_LINEAR,
  output logic          O_CORE_EN,
  output logic          O_AUX_EN,
  output logic          O_REF_EN,
  output logic          O_XCVR_EN,
  output logic          O_AUX_THR_USED,
  output logic          O_DEEP_FS
);
  localparam int NS = 19;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic sclk_s, sel_s, mosi_s, line_low, gate_hi, pre_ss, sel_pre;
  logic rails_ss, pre_uv, bat_uv, wk_can, wk_lin, wk_io, key;
  logic lb_done, lb_ok, ab_done, ab_ok, fault;
  // every pin except I_WD_GOOD and I_WD_ERR passes two flops; only sync2 is read
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {LINK.sclk, !LINK.cs_n, LINK.mosi, !LINK.rst_line,
                I_LOWSIDE_GATE_PIN_HIGH, I_PRE_SS_DONE, I_SELECT_TO_PRE,
                I_RAILS_SS_DONE, I_PRE_UV, I_BAT_UV, I_WAKE_CAN,
                I_WAKE_LIN, I_WAKE_IO, I_KEY, I_LOGIC_SELF_TEST_DONE, I_LOGIC_SELF_TEST_OK,
                I_ANALOG_SELF_TEST_DONE, I_ANALOG_SELF_TEST_OK, I_FAULT};
      sync2 <= sync1;
    end
  end
  assign {sclk_s, sel_s, mosi_s, line_low, gate_hi, pre_ss, sel_pre,
          rails_ss, pre_uv, bat_uv, wk_can, wk_lin, wk_io, key,
          lb_done, lb_ok, ab_done, ab_ok, fault} = sync2;

  sbcseq_main_t m_state;
  sbcseq_fs_t   f_state;
  logic [CNT_W-1:0] m_cnt, f_cnt, t8_cnt;
  logic [DATA_W-1:0] wake_en, wake_src, cfg1, cfg2, sout;
  logic [2:0] err, ref_cnt;
  logic [1:0] rel_age;
  logic [4:0] bit_cnt;
  logic [14:0] sin;
  logic sclk_d, key_d, topo_bb, aux_dis, aux_used, dly_long, init_pend;
  logic rst_assert, miso;
  logic rise, fall, wr_stb, ext_req, go_assert, fs_off, low_power_off_mode;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [CNT_W-1:0] dly_cyc;
  logic [2:0] err_final;

  function automatic logic [DATA_W-1:0] reg_read(
    input logic [ADDR_W-1:0] a);
    case (a)
      A_MAIN_CFG: reg_read = wake_en;
      A_WAKE_SRC: reg_read = wake_src;
      A_FS_CFG1:  reg_read = cfg1;
      A_FS_CFG2:  reg_read = cfg2;
      A_STATUS:   reg_read = {m_state, f_state};
      A_SAFETY:   reg_read = {topo_bb, aux_dis, aux_used, 2'h0, err};
      default:    reg_read = 8'h00;
    endcase
  endfunction

  // serial slave, mode 0
  assign rise    = sclk_s && !sclk_d;
  assign fall    = !sclk_s && sclk_d;
  assign wr_stb  = sel_s && rise && bit_cnt == BIT_LAST && sin[14];
  assign wr_addr = sin[13:7];
  assign wr_data = {sin[6:0], mosi_s};
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      sclk_d  <= 1'b0;
      bit_cnt <= 5'h00;
      sin     <= '0;
      sout    <= '0;
      miso    <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      if (!sel_s) begin
        bit_cnt <= 5'h00;
        miso    <= 1'b0;
      end else if (rise) begin
        sin     <= {sin[13:0], mosi_s};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == BIT_ADDR_LAST) begin
          sout <= reg_read({sin[5:0], mosi_s});
        end
      end else if (fall && bit_cnt > BIT_ADDR_LAST) begin
        miso <= sout[7];
        sout <= {sout[6:0], 1'b0};
      end
    end
  end
  assign LINK.miso = miso;

  assign low_power_off_mode  = m_state inside {M_SLEEP, M_UV_OFF, M_DFS_OFF};
  assign fs_off = f_state == F_OFF;

  // main machine: power sequencing
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      m_state  <= M_TOPO;
      m_cnt    <= '0;
      topo_bb  <= 1'b0;
      aux_dis  <= 1'b0;
      wake_src <= '0;
      key_d    <= 1'b0;
    end else begin
      key_d <= key;
      m_cnt <= m_cnt + 1'b1;
      unique case (m_state)
        M_TOPO: begin
          if (gate_hi) begin
            topo_bb <= 1'b1;
            m_state <= M_PRE_SS;
            m_cnt   <= '0;
          end else if (m_cnt >= CNT_W'(TOPO_CYC - 1)) begin
            topo_bb <= 1'b0;
            m_state <= M_PRE_SS;
          end
        end
        M_PRE_SS: if (pre_ss) m_state <= M_SELECT;
        M_SELECT: begin
          aux_dis <= sel_pre;
          m_state <= M_RAILS;
        end
        M_RAILS: if (rails_ss) m_state <= M_INIT;
        M_INIT, M_NORMAL: begin
          m_cnt <= '0;
          if (pre_uv) begin
            m_state <= M_UV_OFF;
          end else if (wr_stb && wr_addr == A_INIT_LOCK &&
                       m_state == M_INIT) begin
            m_state <= M_NORMAL;
          end else if (wr_stb && wr_addr == A_SLEEP_CMD &&
                       wr_data == SLEEP_KEY && m_state == M_NORMAL) begin
            m_state <= M_SLEEP;
          end
        end
        M_SLEEP: begin
          m_cnt <= '0;
          if ((wk_can && wake_en[WAKE_CAN_BIT]) ||
              (wk_lin && wake_en[WAKE_LIN_BIT]) ||
              (wk_io && wake_en[WAKE_IO_BIT])) begin
            wake_src <= {5'h00, wk_io, wk_lin, wk_can};
            m_state  <= M_TOPO;
          end
        end
        M_UV_OFF: begin
          if (m_cnt >= CNT_W'(UV_CYCLES - 1)) begin
            m_state <= M_TOPO;
            m_cnt   <= '0;
          end
        end
        M_DEEP_WAIT: if (!key) m_state <= M_DFS_OFF;
        M_DFS_OFF: begin
          m_cnt <= '0;
          if (key && !key_d) m_state <= M_TOPO;
        end
        default: m_state <= M_TOPO;
      endcase
      if (f_state == F_DEEP && !low_power_off_mode && m_state != M_DEEP_WAIT) begin
        m_state <= M_DEEP_WAIT;
      end
    end
  end

  // main settings survive low-power-off; only the async reset clears them
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      wake_en <= '0;
    end else if (wr_stb && wr_addr == A_MAIN_CFG && m_state == M_INIT) begin
      wake_en <= wr_data;
    end
  end

  // regulator controls
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_LOWSIDE_GATE_PIN_SRC <= 1'b0;
      O_PRE_EN      <= 1'b0;
      O_PRE_BOOST   <= 1'b0;
      O_PRE_LINEAR  <= 1'b0;
      O_CORE_EN     <= 1'b0;
      O_AUX_EN      <= 1'b0;
      O_REF_EN      <= 1'b0;
      O_XCVR_EN     <= 1'b0;
    end else begin
      O_LOWSIDE_GATE_PIN_SRC <= m_state == M_TOPO;
      O_PRE_EN      <= m_state inside {M_PRE_SS, M_SELECT, M_RAILS,
                       M_INIT, M_NORMAL} || (m_state == M_SLEEP && bat_uv);
      O_PRE_BOOST   <= m_state == M_SLEEP && bat_uv && topo_bb;
      O_PRE_LINEAR  <= m_state == M_SLEEP && bat_uv && !topo_bb;
      O_CORE_EN     <= m_state inside {M_RAILS, M_INIT, M_NORMAL};
      O_REF_EN      <= m_state inside {M_RAILS, M_INIT, M_NORMAL};
      O_XCVR_EN     <= m_state inside {M_RAILS, M_INIT, M_NORMAL};
      O_AUX_EN      <= m_state inside {M_RAILS, M_INIT, M_NORMAL} &&
                       !aux_dis;
    end
  end
  assign O_TOPO_BUCKBOOST = topo_bb;

  // fail-safe machine
  assign ext_req   = line_low && rel_age == REL_SETTLE;
  assign go_assert = fault || ext_req || I_WD_ERR ||
                     (f_state == F_INIT && f_cnt >= CNT_W'(INIT_CYCLES - 1));
  assign dly_cyc   = dly_long ? CNT_W'(LONG_CYCLES) :
                     cfg1[CFG1_DLY_BIT] ? CNT_W'(MID_CYCLES) :
                     CNT_W'(SHRT_CYCLES);
  assign err_final = cfg2[CFG2_FINAL_BIT] ? ERR_FINAL_HI : ERR_FINAL_LO;
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      f_state   <= F_LOGIC_SELF_TEST;
      f_cnt     <= '0;
      err       <= 3'h0;
      ref_cnt   <= 3'h0;
      aux_used  <= 1'b0;
      dly_long  <= 1'b1;
      init_pend <= 1'b1;
    end else if (low_power_off_mode) begin
      f_state   <= F_OFF;
      f_cnt     <= '0;
      err       <= 3'h0;
      ref_cnt   <= 3'h0;
      dly_long  <= 1'b1;
      init_pend <= 1'b1;
    end else begin
      f_cnt <= f_cnt + 1'b1;
      unique case (f_state)
        F_OFF: f_state <= F_LOGIC_SELF_TEST;
        F_LOGIC_SELF_TEST: begin
          if (lb_done) f_state <= lb_ok ? F_SELECT : F_BIST_FAIL;
        end
        F_SELECT: begin
          if (m_state inside {M_RAILS, M_INIT, M_NORMAL}) begin
            aux_used <= !aux_dis;
            f_state  <= F_ANALOG_SELF_TEST;
          end
        end
        F_ANALOG_SELF_TEST: begin
          f_cnt <= '0;
          if (ab_done) f_state <= ab_ok ? F_RST_DELAY : F_BIST_FAIL;
        end
        F_BIST_FAIL: if (t8_cnt >= CNT_W'(DEEP_CYCLES - 1)) f_state <= F_DEEP;
        F_RST_DELAY: begin
          if (err >= err_final ||
              t8_cnt >= CNT_W'(DEEP_CYCLES - 1)) begin
            f_state <= F_DEEP;
          end else if (f_cnt >= dly_cyc - 1'b1 && !fault &&
                       m_state inside {M_INIT, M_NORMAL}) begin
            f_state  <= init_pend ? F_INIT : F_NORMAL;
            dly_long <= 1'b0;
            f_cnt    <= '0;
          end
        end
        F_INIT, F_NORMAL: begin
          if (go_assert) begin
            f_state <= F_RST_DELAY;
            f_cnt   <= '0;
            err     <= err + 3'h1;
            ref_cnt <= 3'h0;
          end else if (I_WD_GOOD) begin
            f_state   <= F_NORMAL;
            init_pend <= 1'b0;
            ref_cnt   <= (ref_cnt == REFRESH_LIM) ? 3'h0 : ref_cnt + 3'h1;
            if (ref_cnt == REFRESH_LIM && err != 3'h0) err <= err - 3'h1;
          end
        end
        F_DEEP: f_cnt <= '0;
        default: f_state <= F_LOGIC_SELF_TEST;
      endcase
    end
  end

  // fail-safe settings: writable only in INIT FS, erased with the machine
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg1 <= '0;
      cfg2 <= '0;
    end else if (fs_off) begin
      cfg1 <= '0;
      cfg2 <= '0;
    end else if (wr_stb && f_state == F_INIT) begin
      if (wr_addr == A_FS_CFG1) cfg1 <= wr_data;
      if (wr_addr == A_FS_CFG2) cfg2 <= wr_data;
    end
  end

  // 8 s supervision: runs from select until release, and in each reset
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      t8_cnt <= '0;
    end else if (f_state == F_BIST_FAIL ||
                 (f_state inside {F_SELECT, F_ANALOG_SELF_TEST, F_RST_DELAY} &&
                  !cfg2[CFG2_T8DIS_BIT])) begin
      t8_cnt <= t8_cnt + 1'b1;
    end else begin
      t8_cnt <= '0;
    end
  end

  // synced line lags our own release, so ignore it for a few cycles
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_assert <= 1'b1;
      rel_age    <= 2'h0;
      O_DEEP_FS  <= 1'b0;
    end else begin
      rst_assert <= !(f_state inside {F_INIT, F_NORMAL});
      rel_age    <= rst_assert ? 2'h0 :
                    (rel_age == REL_SETTLE ? rel_age : rel_age + 2'h1);
      O_DEEP_FS  <= f_state == F_DEEP;
    end
  end
  assign LINK.rst_dev_o    = 1'b0;
  assign LINK.rst_dev_oe_n = !rst_assert;
  assign O_AUX_THR_USED    = aux_used;
endmodule
`default_nettype wire

/* shared/sbcseq_pkg.sv */
`default_nettype none
package sbcseq_pkg;
  localparam int CLK_KHZ = 25000;
  localparam int CNT_W   = 28;
  // times as specified, in their own unit
  localparam int T_TOPO_US     = 120;
  localparam int T_UV_RETRY_US = 1000;
  localparam int T_INIT_FS_MS  = 256;
  localparam int T_RST_LONG_MS = 16;
  localparam int T_RST_MID_MS  = 10;
  localparam int T_RST_SHRT_MS = 1;
  localparam int T_DEEP_MS     = 8000;
  // timeout: rounded down
  localparam int TOPO_CYC = (T_TOPO_US * CLK_KHZ) / 1000;
  localparam int UV_CYC   = (T_UV_RETRY_US * CLK_KHZ) / 1000;
  localparam int INIT_CYC = T_INIT_FS_MS * CLK_KHZ;
  localparam int LONG_CYC = T_RST_LONG_MS * CLK_KHZ;
  localparam int MID_CYC  = T_RST_MID_MS * CLK_KHZ;
  localparam int SHRT_CYC = T_RST_SHRT_MS * CLK_KHZ;
  localparam int DEEP_CYC = T_DEEP_MS * CLK_KHZ;
  // serial frame: write flag, 7-bit address, 8-bit data, msb first
  localparam int FRAME_BITS = 16;
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 8;
  localparam int SCLK_HALF  = 4;
  localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
  localparam logic [4:0] BIT_LAST      = 5'h0F;
  localparam logic [ADDR_W-1:0] A_INIT_LOCK = 7'h01;
  localparam logic [ADDR_W-1:0] A_MAIN_CFG  = 7'h02;
  localparam logic [ADDR_W-1:0] A_SLEEP_CMD = 7'h03;
  localparam logic [ADDR_W-1:0] A_WAKE_SRC  = 7'h04;
  localparam logic [ADDR_W-1:0] A_FS_CFG1   = 7'h10;
  localparam logic [ADDR_W-1:0] A_FS_CFG2   = 7'h11;
  localparam logic [ADDR_W-1:0] A_STATUS    = 7'h20;
  localparam logic [ADDR_W-1:0] A_SAFETY    = 7'h21;
  localparam logic [DATA_W-1:0] SLEEP_KEY   = 8'h5A;
  localparam int WAKE_CAN_BIT   = 0;
  localparam int WAKE_LIN_BIT   = 1;
  localparam int WAKE_IO_BIT    = 2;
  localparam int CFG1_DLY_BIT   = 0;
  localparam int CFG2_FINAL_BIT = 0;
  localparam int CFG2_T8DIS_BIT = 1;
  localparam logic [2:0] ERR_FINAL_LO = 3'h2;
  localparam logic [2:0] ERR_FINAL_HI = 3'h6;
  localparam logic [2:0] REFRESH_LIM  = 3'h6;
  localparam logic [1:0] REL_SETTLE   = 2'h3;
  typedef enum logic [3:0] {
    M_TOPO = 4'h0, M_PRE_SS = 4'h1, M_SELECT = 4'h2, M_RAILS = 4'h3,
    M_INIT = 4'h4, M_NORMAL = 4'h5, M_SLEEP = 4'h6, M_UV_OFF = 4'h7,
    M_DEEP_WAIT = 4'h8, M_DFS_OFF = 4'h9
  } sbcseq_main_t;
  typedef enum logic [3:0] {
    F_LOGIC_SELF_TEST = 4'h0, F_SELECT = 4'h1, F_ANALOG_SELF_TEST = 4'h2, F_BIST_FAIL = 4'h3,
    F_RST_DELAY = 4'h4, F_INIT = 4'h5, F_NORMAL = 4'h6, F_DEEP = 4'h7,
    F_OFF = 4'h8
  } sbcseq_fs_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_SEND = 2'h1, H_GAP = 2'h2
  } sbcseq_host_t;
endpackage
`default_nettype wire

/* shared/sbcseq_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sbcseq_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic rst_dev_o;
  logic rst_dev_oe_n;
  logic rst_host_o;
  logic rst_host_oe_n;
  logic rst_line;
  // open-drain reset wire with pull-up
  assign rst_line = !((!rst_dev_oe_n && !rst_dev_o) ||
                      (!rst_host_oe_n && !rst_host_o));
  modport dev  (input sclk, cs_n, mosi, rst_line,
                output miso, rst_dev_o, rst_dev_oe_n);
  modport host (output sclk, cs_n, mosi, rst_host_o, rst_host_oe_n,
                input miso, rst_line);
endinterface
`default_nettype wire

/* verilog/sbcseq_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sbcseq_host import sbcseq_pkg::*; (
  input  wire logic              I_CLOCK,
  input  wire logic              I_NRST,
  sbcseq_link_if.host            LINK,
  input  wire logic [DATA_W-1:0] I_MAIN_CFG,
  input  wire logic [DATA_W-1:0] I_FS_CFG1,
  input  wire logic [DATA_W-1:0] I_FS_CFG2,
  input  wire logic              I_REQ_VALID,
  input  wire logic              I_REQ_WRITE,
  input  wire logic [ADDR_W-1:0] I_REQ_ADDR,
  input  wire logic [DATA_W-1:0] I_REQ_DATA,
  input  wire logic              I_RST_ERR_ZERO,
  input  wire logic              I_EXT_RESET,
  output logic                   O_REQ_READY,
  output logic                   O_RSP_VALID,
  output logic [DATA_W-1:0]      O_RSP_DATA,
  output logic                   O_MCU_RESET_N,
  output logic                   O_INIT_DONE
);
  sbcseq_host_t h_state;
  logic [1:0] sync1, sync2;
  logic [2:0] div;
  logic [4:0] bits;
  logic [1:0] step;
  logic [FRAME_BITS-1:0] sh;
  logic [DATA_W-1:0] rx;
  logic sclk, cs_n, boot, user_frm, line_d, ext_q, tick, is_sleep;
  logic [FRAME_BITS-1:0] boot_frm;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {LINK.miso, LINK.rst_line};
      sync2 <= sync1;
    end
  end

  always_comb begin
    unique case (step)
      2'h0: boot_frm = {1'b1, A_MAIN_CFG, I_MAIN_CFG};
      2'h1: boot_frm = {1'b1, A_FS_CFG1, I_FS_CFG1};
      2'h2: boot_frm = {1'b1, A_FS_CFG2, I_FS_CFG2};
      2'h3: boot_frm = {1'b1, A_INIT_LOCK, 8'h00};
    endcase
  end

  // sleep is held back until software reports a cleared error count
  // the release cycle itself is refused, so the boot frames go first
  assign is_sleep    = I_REQ_WRITE && I_REQ_ADDR == A_SLEEP_CMD;
  assign O_REQ_READY = h_state == H_IDLE && !boot && sync2[0] && line_d &&
                       (!is_sleep || I_RST_ERR_ZERO);
  assign tick        = div == 3'(SCLK_HALF - 1);

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      div <= 3'h0;
    end else begin
      div <= (tick || h_state == H_IDLE) ? 3'h0 : div + 3'h1;
    end
  end

  // fail-safe and init settings are resent after every release; the device only takes them while in INIT
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      h_state     <= H_IDLE;
      sclk        <= 1'b0;
      cs_n        <= 1'b1;
      bits        <= 5'h00;
      sh          <= '0;
      rx          <= '0;
      step        <= 2'h0;
      boot        <= 1'b0;
      user_frm    <= 1'b0;
      line_d      <= 1'b0;
      O_RSP_VALID <= 1'b0;
      O_RSP_DATA  <= '0;
      O_INIT_DONE <= 1'b0;
    end else begin
      line_d      <= sync2[0];
      O_RSP_VALID <= 1'b0;
      if (!sync2[0]) begin
        O_INIT_DONE <= 1'b0;
      end
      if (sync2[0] && !line_d) begin
        boot <= 1'b1;
        step <= 2'h0;
      end
      unique case (h_state)
        H_IDLE: begin
          if (boot && sync2[0]) begin
            sh       <= boot_frm;
            user_frm <= 1'b0;
            cs_n     <= 1'b0;
            bits     <= 5'h00;
            h_state  <= H_SEND;
          end else if (I_REQ_VALID && O_REQ_READY) begin
            sh       <= {I_REQ_WRITE, I_REQ_ADDR, I_REQ_DATA};
            user_frm <= 1'b1;
            cs_n     <= 1'b0;
            bits     <= 5'h00;
            h_state  <= H_SEND;
          end
        end
        H_SEND: begin
          if (tick) begin
            sclk <= !sclk;
            if (sclk) begin
              rx <= {rx[6:0], sync2[1]};
              sh <= {sh[FRAME_BITS-2:0], 1'b0};
              bits <= bits + 5'h01;
              if (bits == BIT_LAST) begin
                h_state <= H_GAP;
                cs_n    <= 1'b1;
              end
            end
          end
        end
        H_GAP: begin
          if (tick) begin
            h_state <= H_IDLE;
            if (user_frm) begin
              O_RSP_VALID <= 1'b1;
              O_RSP_DATA  <= rx;
            end else if (step == 2'h3) begin
              boot        <= 1'b0;
              O_INIT_DONE <= 1'b1;
            end else begin
              step <= step + 2'h1;
            end
          end
        end
        default: h_state <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= I_EXT_RESET;
    end
  end
  assign LINK.sclk          = sclk;
  assign LINK.cs_n          = cs_n;
  assign LINK.mosi          = sh[FRAME_BITS-1];
  assign LINK.rst_host_o    = 1'b0;
  assign LINK.rst_host_oe_n = !ext_q;
  assign O_MCU_RESET_N      = sync2[0];
endmodule
`default_nettype wire

/* bench/sbcseq_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sbcseq_link_monitor (
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic rst_dev_o,
  input wire logic rst_dev_oe_n,
  input wire logic rst_host_o,
  input wire logic rst_host_oe_n,
  input wire logic rst_line
);
  logic       sclk_d;
  logic [4:0] rises;
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) sclk_d <= 1'b0;
    else sclk_d <= sclk;
  end
  // cleared between frames so every frame is counted on its own
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) rises <= 5'h00;
    else if (cs_n) rises <= 5'h00;
    else if (sclk && !sclk_d) rises <= rises + 5'h01;
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);
  property p_idle_low; cs_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low) else $error("sclk out of frame");
  property p_high; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_high: assert property (p_high) else $error("sclk high time");
  property p_lead; $fell(cs_n) |-> !sclk [*4] ##1 sclk; endproperty
  a_lead: assert property (p_lead) else $error("frame lead time");
  property p_mosi; $rose(sclk) |-> $stable(mosi) [*4]; endproperty
  a_mosi: assert property (p_mosi) else $error("mosi moved");
  property p_len; $rose(cs_n) |-> rises == 5'h10; endproperty
  a_len: assert property (p_len) else $error("frame length");
  property p_miso; cs_n [*4] |-> !miso; endproperty
  a_miso: assert property (p_miso) else $error("miso out of frame");
  property p_dev_od; !rst_dev_oe_n |-> !rst_dev_o && !rst_line; endproperty
  a_dev_od: assert property (p_dev_od) else $error("reset drive");
  property p_host_od; !rst_host_oe_n |-> !rst_host_o; endproperty
  a_host_od: assert property (p_host_od) else $error("ext reset drive");
  property p_boot; $rose(rst_line) |-> cs_n [*2]; endproperty
  a_boot: assert property (p_boot) else $error("frame at release");
  c_frame: cover property ($rose(cs_n) && rises == 5'h10);
  c_release: cover property ($rose(rst_line));
  c_ext: cover property (!rst_host_oe_n);
endmodule
`default_nettype wire

/* bench/sbc_mode_and_failsafe_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_and_failsafe_sequencer_bench import sbcseq_pkg::*; ;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic gate, sel, ss, bist, bat_uv, can, lin, io, key, fault, good;
  logic ezero, ext, valid, wr, ready, rsp_v, rst_n, done, pre_uv, wderr;
  logic gsrc, topo, pre_en, boost, lin_m, core, aux, ref_en, xcvr, thr, deep;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data, mcfg, rsp_d, fcfg1, fcfg2;
  logic [DATA_W:0]   exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 54283;
  sbcseq_link_if link();
  sbcseq_device #(.UV_CYCLES(50), .INIT_CYCLES(2000), .LONG_CYCLES(300),
    .MID_CYCLES(200), .SHRT_CYCLES(100), .DEEP_CYCLES(5000)) u_sbcseq_device (
    .I_CLOCK(clk), .I_NRST(nrst), .LINK(link), .I_LOWSIDE_GATE_PIN_HIGH(gate),
    .I_PRE_SS_DONE(ss), .I_SELECT_TO_PRE(sel), .I_RAILS_SS_DONE(ss),
    .I_PRE_UV(pre_uv), .I_BAT_UV(bat_uv), .I_WAKE_CAN(can), .I_WAKE_LIN(lin),
    .I_WAKE_IO(io), .I_KEY(key), .I_LOGIC_SELF_TEST_DONE(bist), .I_LOGIC_SELF_TEST_OK(bist),
    .I_ANALOG_SELF_TEST_DONE(bist), .I_ANALOG_SELF_TEST_OK(bist), .I_FAULT(fault), .I_WD_GOOD(good),
    .I_WD_ERR(wderr), .O_LOWSIDE_GATE_PIN_SRC(gsrc), .O_TOPO_BUCKBOOST(topo),
    .O_PRE_EN(pre_en), .O_PRE_BOOST(boost), .O_PRE_LINEAR(lin_m),
    .O_CORE_EN(core), .O_AUX_EN(aux), .O_REF_EN(ref_en), .O_XCVR_EN(xcvr),
    .O_AUX_THR_USED(thr), .O_DEEP_FS(deep));
  sbcseq_host u_sbcseq_host (.I_CLOCK(clk), .I_NRST(nrst), .LINK(link),
    .I_MAIN_CFG(mcfg), .I_FS_CFG1(fcfg1), .I_FS_CFG2(fcfg2),
    .I_REQ_VALID(valid), .I_REQ_WRITE(wr), .I_REQ_ADDR(addr),
    .I_REQ_DATA(data), .I_RST_ERR_ZERO(ezero), .I_EXT_RESET(ext),
    .O_REQ_READY(ready), .O_RSP_VALID(rsp_v), .O_RSP_DATA(rsp_d),
    .O_MCU_RESET_N(rst_n), .O_INIT_DONE(done));
  sbcseq_link_monitor u_sbcseq_link_monitor (.I_CLOCK(clk), .I_NRST(nrst),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
    .rst_dev_o(link.rst_dev_o), .rst_dev_oe_n(link.rst_dev_oe_n),
    .rst_host_o(link.rst_host_o), .rst_host_oe_n(link.rst_host_oe_n),
    .rst_line(link.rst_line));
  initial forever #20 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check(input string nm, input logic [DATA_W-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // e[DATA_W] marks a read; for a write the low byte is the data sent
  task automatic req(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W:0] e);
    exp_q.push_back(e);
    valid = 1'b1;
    wr = w;
    addr = a;
    data = e[DATA_W-1:0];
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    tick(1);
    valid = 1'b0;
    @(posedge rsp_v);
    tick(1);
  endtask
  always @(negedge clk) begin
    if (rsp_v === 1'b1) begin
      if (exp_q.size() == 0) check("spare response", 8'h01, 8'h00);
      else if (exp_q[0][DATA_W]) check("read", rsp_d, exp_q[0][7:0]);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  task automatic give_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {sel, ss, bat_uv, can, lin, io, fault, good, ezero, ext, valid, wr} = '0;
    {gate, bist, key} = 3'b111;
    {pre_uv, wderr} = 2'h0;
    addr = '0;
    data = '0;
    // can and io wake stay masked so a stray edge on them is caught
    mcfg = (8'($random(seed)) & 8'hFA) | 8'h02;
    sel = 1'($random(seed));
    fcfg1 = 8'($random(seed)) & 8'h01;
    fcfg2 = 8'h01;
    tick(8);
    nrst = 1'b1;
    tick(20);
    check("topology", topo, 1'b1);
    check("rails early", core, 1'b0);
    ss = 1'b1;
    tick(12);
    check("rails", {core, ref_en, xcvr}, 3'h7);
    check("aux", aux, !sel);
    check("aux thresholds", thr, !sel);
    wait (done === 1'b1 && rst_n === 1'b1);
    tick(1);
    good = 1'b1;
    tick(1);
    good = 1'b0;
    req(1'b0, A_STATUS, {1'b1, M_NORMAL, F_NORMAL});
    wderr = 1'b1;
    tick(1);
    wderr = 1'b0;
    tick(8);
    check("refresh error reset", rst_n, 1'b0);
    wait (done === 1'b1 && rst_n === 1'b1);
    tick(1);
    ext = 1'b1;
    tick(8);
    check("ext reset", rst_n, 1'b0);
    ext = 1'b0;
    wait (done === 1'b1 && rst_n === 1'b1);
    tick(1);
    // two resets, each worth seven good refreshes
    repeat (14) begin
      good = 1'b1;
      tick(1);
      good = 1'b0;
      tick(1);
    end
    req(1'b0, A_SAFETY, {2'h3, sel, !sel, 5'h00});
    req(1'b0, A_FS_CFG1, {1'b1, fcfg1});
    ezero = 1'b1;
    req(1'b1, A_SLEEP_CMD, {1'b0, SLEEP_KEY});
    tick(12);
    check("sleep rails", {core, aux, ref_en, xcvr, pre_en}, 5'h00);
    bat_uv = 1'b1;
    tick(8);
    check("sleep boost", {pre_en, boost, lin_m}, 3'h6);
    bat_uv = 1'b0;
    can = 1'b1;
    io = 1'b1;
    tick(6);
    check("masked wake", {gsrc, pre_en}, 2'h0);
    can = 1'b0;
    io = 1'b0;
    lin = 1'b1;
    tick(4);
    lin = 1'b0;
    req(1'b0, A_WAKE_SRC, {1'b1, 8'(1 << WAKE_LIN_BIT)});
    fault = 1'b1;
    wait (deep === 1'b1);
    tick(2);
    check("deep rails", {core, pre_en}, 2'h0);
    fault = 1'b0;
    key = 1'b0;
    tick(10);
    key = 1'b1;
    tick(20);
    check("key wake", deep, 1'b0);
    pre_uv = 1'b1;
    tick(6);
    check("uv off", {core, pre_en}, 2'h0);
    pre_uv = 1'b0;
    tick(70);
    check("uv retry", {core, pre_en}, 2'h3);
    give_verdict();
  end
endmodule
`default_nettype wire
